// ===== common/lcdci_consts.svh
// Constants of the display command interpreter
`ifndef LCDCI_CONSTS_SVH
`define LCDCI_CONSTS_SVH
// ==========================================================
// Command type codes, low six bits
`define LCDCI_T_ECHO 6'h00
`define LCDCI_T_VER 6'h01
`define LCDCI_T_UWR 6'h02
`define LCDCI_T_URD 6'h03
`define LCDCI_T_SAVE 6'h04
`define LCDCI_T_RST 6'h05
`define LCDCI_T_CLR 6'h06
`define LCDCI_T_GLY 6'h09
`define LCDCI_T_MRD 6'h0A
// ==========================================================
// Answer and command type upper bits
`define LCDCI_ACK_HI 2'h1
`define LCDCI_ERR_HI 2'h3
`define LCDCI_CMD_HI 2'h0
// ==========================================================
// Payload lengths
`define LCDCI_ECHO_MAX 5'h10
`define LCDCI_USER_LEN 5'h10
`define LCDCI_VER_LEN 5'h10
`define LCDCI_RST_LEN 5'h03
`define LCDCI_GLY_LEN 5'h09
`define LCDCI_MRD_LEN 5'h01
`define LCDCI_MRD_RLEN 5'h09
`define LCDCI_NONE_LEN 5'h00
// ==========================================================
// Restart payloads
`define LCDCI_REBOOT_KEY 24'h08_1263
`define LCDCI_HRST_KEY 24'h0C_1C61
`define LCDCI_POFF_KEY 24'h03_0B5F
// ==========================================================
// Memory map of both images
`define LCDCI_BLANK 8'h20
`define LCDCI_GLY_HI 2'h1
`define LCDCI_ROW_LAST 3'h7
`define LCDCI_USER_LAST 4'hF
`define LCDCI_SWEEP_FIRST 9'h010
`define LCDCI_DISP_FIRST 9'h080
`define LCDCI_CUR_COL_ADDR 8'h10
`define LCDCI_CUR_ROW_ADDR 8'h11
`define LCDCI_IMG_FIRST 8'h40
`define LCDCI_LAST_ADDR 8'hFF
`define LCDCI_COL_MAX 5'h13
// ==========================================================
// Timing and reset values
`define LCDCI_CLK_HZ 25000000
`define LCDCI_MS_PER_S 1000
`define LCDCI_HRST_MS 12'h5DC
`define LCDCI_QUIET_MS 12'hBB8
`define LCDCI_FAN_MS 10'h1F4
`define LCDCI_FAN_PCT 8'h64
`define LCDCI_RST_BYTE 8'h00
`endif

// ===== common/lcdci_pkg.sv
// Types of the display command interpreter
package lcdci_pkg;
	typedef enum logic [3:0] {
		S_BOOT, S_IDLE, S_EXEC, S_UWR, S_URD, S_SAVE, S_VERIFY,
		S_CLEAR, S_GLYPH, S_MEMRD, S_SEND, S_HOLD, S_QUIET
	} lcdci_state_t;
	typedef enum logic [1:0] {
		ACT_NONE, ACT_REBOOT, ACT_HRST, ACT_POFF
	} lcdci_act_t;
endpackage : lcdci_pkg

// ===== verilog/lcdci_mem.sv
// Single port byte memory with registered read data
`timescale 1ns/100ps
module lcdci_mem #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	// Clock
	input wire logic clk,
	// Access
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [2**AW];

	// ==========================================================
	// Read first: write stores, read returns the old word
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule : lcdci_mem

// ===== verilog/lcdci_core.sv
// Command interpreter of the character display module
//
// Summary of operation
// [R01] Every received command packet gets exactly one answer packet.
// [R02] Answer type keeps command low six bits; success sets bit 6.
// [R03] Errors set both upper bits; unknown type, bad length, bad value.
// [R04] Echo of up to 16 bytes returns same length and bytes.
// [R05] Version query returns fixed 16-byte revision text.
// [R06] User write needs exactly 16 bytes, stored nonvolatile, empty ack.
// [R07] User read returns the 16 stored nonvolatile bytes.
// [R08] At power-up the whole start-up image is loaded from storage.
// [R09] Save copies screen, glyphs and cursor to storage, then acks.
// [R10] Reporting, fail-safe and watchdog selections are never saved.
// [R11] Saved image is verified; mismatch gives error instead of ack.
// [R12] Payload 8,18,99: ack at once, then full restart.
// [R13] Payload 12,28,97: ack, drive host reset pin, then restart.
// [R14] Host reset lasts 1.5 s; after restart ignore packets up to 3 s.
// [R15] Payload 3,11,95: ack, power pulse of set length, restart, quiet.
// [R16] Every accepted restart variant is acked with empty payload.
// [R17] Power switch pins must stay in their default mode.
// [R18] Fans switch on at 100 percent within 500 ms of start-up.
// [R19] Clear fills display text with blanks and homes the cursor.
// [R20] Glyph command: index 0 to 7, eight rows each 0 to 63.
// [R21] Glyph rows stored top to bottom, high used bit at left.
// [R22] Memory read echoes address then returns eight memory bytes.
// [R23] Only glyph and four display line windows may be read.
// [R24] Answer stream ends at last payload byte; CRC follows outside.
// [R25] Every packet is answered well within 250 ms.
// [R26] Bytes arrive from a 115200 baud 8N1 receiver.
`timescale 1ns/100ps
`include "lcdci_consts.svh"
module lcdci_core import lcdci_pkg::*; #(
	parameter int CYC_PER_MS = `LCDCI_CLK_HZ / `LCDCI_MS_PER_S,
	// Arbitrary neutral revision text
	parameter logic [127:0] VERSION =
		128'h2D2D_2D2D_2D2D_2D2D_2D2D_2D2D_2D2D_2D2D
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Received packet bytes
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_end,
	output logic rx_ready,
	// Answer packet bytes
	output logic tx_valid,
	output logic [7:0] tx_byte,
	output logic tx_last,
	input wire logic tx_ready,
	// Power switch setting
	input wire logic [11:0] pulse_ms,
	// Host control and fans
	output logic host_reset_drive,
	output logic host_power_drive,
	output logic [7:0] fan_power,
	// Cursor
	output logic [7:0] cursor_col,
	output logic [7:0] cursor_row
);
	localparam int DIV_W = $clog2(CYC_PER_MS);

	lcdci_state_t state;
	lcdci_act_t act;
	logic [DIV_W-1:0] div;
	logic ms_tick;
	logic [9:0] fan_ms;
	logic [4:0] rx_cnt;
	logic [7:0] rtype;
	logic [4:0] rlen;
	logic [7:0] pay [16];
	logic [7:0] obuf [16];
	logic [8:0] cnt;
	logic [7:0] cnt_d;
	logic dv;
	logic [4:0] sidx;
	logic [7:0] rsp_type;
	logic [4:0] rsp_len;
	logic [2:0] gidx;
	logic [7:0] maddr;
	logic quiet;
	logic mis;
	logic [11:0] tmr;
	logic l_we, b_we;
	logic [7:0] l_addr, b_addr, l_wd, b_wd, l_rd, b_rd;
	logic w_ok, mis_now, bad_rows, addr_ok;
	logic [7:0] src, sel_byte;
	logic [23:0] key;

	// ==========================================================
	// Live display image and nonvolatile image
	lcdci_mem #(.AW(8), .DW(8)) u_live (
		.clk(clk), .we(l_we), .addr(l_addr), .wdata(l_wd), .rdata(l_rd)
	);
	lcdci_mem #(.AW(8), .DW(8)) u_boot (
		.clk(clk), .we(b_we), .addr(b_addr), .wdata(b_wd), .rdata(b_rd)
	);

	// ==========================================================
	// Millisecond tick
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div <= '0;
			ms_tick <= 1'b0;
		end else begin
			ms_tick <= (div == DIV_W'(CYC_PER_MS - 1));
			if (div == DIV_W'(CYC_PER_MS - 1)) begin
				div <= '0;
			end else begin
				div <= div + DIV_W'(1);
			end
		end
	end

	// ==========================================================
	// Fan start after each boot
	always_ff @(posedge clk) begin
		if (!rst_n || state == S_BOOT) begin
			fan_ms <= '0;
			fan_power <= `LCDCI_RST_BYTE;
		end else if (fan_ms == `LCDCI_FAN_MS) begin
			fan_power <= `LCDCI_FAN_PCT; // [R18]
		end else if (ms_tick) begin
			fan_ms <= fan_ms + 10'h001; // [R18]
		end
	end

	// ==========================================================
	// Packet capture
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_cnt <= '0;
			rtype <= `LCDCI_RST_BYTE;
			rlen <= '0;
			for (int i = 0; i < 16; i++) begin
				pay[i] <= `LCDCI_RST_BYTE;
			end
		end else if (state != S_IDLE) begin
			rx_cnt <= '0;
		end else if (rx_valid && rx_ready) begin // [R26]
			if (rx_cnt == 5'h00) begin
				rtype <= rx_byte;
			end else if (rx_cnt == 5'h01) begin
				rlen <= (rx_byte > 8'h1F) ? 5'h1F : rx_byte[4:0];
			end else if (rx_cnt < 5'h12) begin
				pay[4'(rx_cnt - 5'h02)] <= rx_byte;
			end
			if (rx_cnt != 5'h1F) begin
				rx_cnt <= rx_cnt + 5'h01;
			end
		end
	end

	// ==========================================================
	// Parameter checks and byte selection
	always_comb begin
		bad_rows = 1'b0;
		for (int i = 1; i < 9; i++) begin
			bad_rows = bad_rows | (pay[i][7:6] != 2'h0); // [R20]
		end
		addr_ok = (pay[0][7:6] == `LCDCI_GLY_HI) ||
			(pay[0][7] && pay[0][4:0] <= `LCDCI_COL_MAX); // [R23]
		key = {pay[0], pay[1], pay[2]};
		// Only screen, glyphs and cursor belong to the image
		w_ok = (cnt_d >= `LCDCI_IMG_FIRST) ||
			(cnt_d == `LCDCI_CUR_COL_ADDR) ||
			(cnt_d == `LCDCI_CUR_ROW_ADDR); // [R10]
		src = (cnt_d == `LCDCI_CUR_COL_ADDR) ? cursor_col :
			(cnt_d == `LCDCI_CUR_ROW_ADDR) ? cursor_row : l_rd;
		mis_now = dv && w_ok && (src != b_rd); // [R11]
		if (sidx == 5'h00) begin
			sel_byte = rsp_type;
		end else if (sidx == 5'h01) begin
			sel_byte = {3'h0, rsp_len};
		end else begin
			sel_byte = obuf[4'(sidx - 5'h02)];
		end
	end

	// ==========================================================
	// Memory port steering
	always_comb begin
		l_we = 1'b0;
		l_addr = cnt[7:0];
		l_wd = `LCDCI_RST_BYTE;
		b_we = 1'b0;
		b_addr = cnt[7:0];
		b_wd = `LCDCI_RST_BYTE;
		unique case (state)
			S_BOOT: begin
				l_we = dv && (cnt_d >= `LCDCI_IMG_FIRST); // [R08]
				l_addr = cnt_d;
				l_wd = b_rd;
			end
			S_SAVE: begin
				b_we = dv && w_ok; // [R09]
				b_addr = cnt_d;
				b_wd = src;
			end
			S_UWR: begin
				b_we = 1'b1; // [R06]
				b_wd = pay[cnt[3:0]];
			end
			S_CLEAR: begin
				l_we = 1'b1;
				l_wd = `LCDCI_BLANK; // [R19]
			end
			S_GLYPH: begin
				l_we = 1'b1;
				l_addr = {`LCDCI_GLY_HI, gidx, cnt[2:0]}; // [R21]
				l_wd = pay[4'({1'b0, cnt[2:0]} + 4'h1)]; // [R21]
			end
			S_MEMRD: begin
				l_addr = maddr + cnt[7:0]; // [R22]
			end
			S_IDLE, S_EXEC, S_URD, S_VERIFY, S_SEND, S_HOLD, S_QUIET: begin
			end
		endcase
	end

	// ==========================================================
	// Command sequencer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= S_BOOT;
			act <= ACT_NONE;
			cnt <= `LCDCI_SWEEP_FIRST;
			cnt_d <= `LCDCI_RST_BYTE;
			dv <= 1'b0;
			rx_ready <= 1'b0;
			tx_valid <= 1'b0;
			tx_byte <= `LCDCI_RST_BYTE;
			tx_last <= 1'b0;
			sidx <= '0;
			rsp_type <= `LCDCI_RST_BYTE;
			rsp_len <= '0;
			gidx <= '0;
			maddr <= `LCDCI_RST_BYTE;
			quiet <= 1'b0;
			mis <= 1'b0;
			tmr <= '0;
			host_reset_drive <= 1'b0;
			host_power_drive <= 1'b0;
			cursor_col <= `LCDCI_RST_BYTE;
			cursor_row <= `LCDCI_RST_BYTE;
			for (int i = 0; i < 16; i++) begin
				obuf[i] <= `LCDCI_RST_BYTE;
			end
		end else begin
			dv <= 1'b0;
			cnt_d <= cnt[7:0];
			unique case (state)
				S_BOOT: begin
					if (!cnt[8]) begin
						cnt <= cnt + 9'h001;
						dv <= 1'b1;
					end
					if (dv && cnt_d == `LCDCI_CUR_COL_ADDR) begin
						cursor_col <= b_rd; // [R08]
					end
					if (dv && cnt_d == `LCDCI_CUR_ROW_ADDR) begin
						cursor_row <= b_rd; // [R08]
					end
					if (dv && cnt_d == `LCDCI_LAST_ADDR) begin
						quiet <= 1'b0;
						tmr <= `LCDCI_QUIET_MS;
						state <= quiet ? S_QUIET : S_IDLE; // [R14]
						rx_ready <= !quiet;
					end
				end
				S_IDLE: begin
					rx_ready <= !rx_end;
					if (rx_end) begin
						state <= S_EXEC;
					end
				end
				S_EXEC: begin
					rsp_type <= {`LCDCI_ERR_HI, rtype[5:0]}; // [R03]
					rsp_len <= `LCDCI_NONE_LEN;
					act <= ACT_NONE;
					sidx <= '0;
					cnt <= '0;
					mis <= 1'b0;
					state <= S_SEND; // [R25]
					if (rtype[7:6] == `LCDCI_CMD_HI) begin
						case (rtype[5:0])
							`LCDCI_T_ECHO: if (rlen <= `LCDCI_ECHO_MAX) begin
								rsp_type <= {`LCDCI_ACK_HI, rtype[5:0]}; // [R02]
								rsp_len <= rlen; // [R04]
								for (int i = 0; i < 16; i++) begin
									obuf[i] <= pay[i]; // [R04]
								end
							end
							`LCDCI_T_VER: if (rlen == `LCDCI_NONE_LEN) begin
								rsp_type <= {`LCDCI_ACK_HI, rtype[5:0]};
								rsp_len <= `LCDCI_VER_LEN;
								for (int i = 0; i < 16; i++) begin
									obuf[i] <= VERSION[(15 - i) * 8 +: 8]; // [R05]
								end
							end
							`LCDCI_T_UWR: if (rlen == `LCDCI_USER_LEN) begin
								rsp_type <= {`LCDCI_ACK_HI, rtype[5:0]};
								state <= S_UWR; // [R06]
							end
							`LCDCI_T_URD: if (rlen == `LCDCI_NONE_LEN) begin
								rsp_type <= {`LCDCI_ACK_HI, rtype[5:0]};
								state <= S_URD; // [R07]
							end
							`LCDCI_T_SAVE: if (rlen == `LCDCI_NONE_LEN) begin
								cnt <= `LCDCI_SWEEP_FIRST;
								state <= S_SAVE; // [R09]
							end
							`LCDCI_T_RST: if (rlen == `LCDCI_RST_LEN) begin
								if (key == `LCDCI_REBOOT_KEY) begin
									act <= ACT_REBOOT; // [R12]
								end else if (key == `LCDCI_HRST_KEY) begin
									act <= ACT_HRST; // [R13]
								end else if (key == `LCDCI_POFF_KEY) begin
									act <= ACT_POFF; // [R15]
								end
								if (key == `LCDCI_REBOOT_KEY || key == `LCDCI_HRST_KEY ||
									key == `LCDCI_POFF_KEY) begin
									rsp_type <= {`LCDCI_ACK_HI, rtype[5:0]}; // [R16]
								end
							end
							`LCDCI_T_CLR: if (rlen == `LCDCI_NONE_LEN) begin
								rsp_type <= {`LCDCI_ACK_HI, rtype[5:0]};
								cnt <= `LCDCI_DISP_FIRST;
								state <= S_CLEAR; // [R19]
							end
							`LCDCI_T_GLY: if (rlen == `LCDCI_GLY_LEN && pay[0] < 8'h08 &&
								!bad_rows) begin // [R20]
								rsp_type <= {`LCDCI_ACK_HI, rtype[5:0]};
								gidx <= pay[0][2:0];
								state <= S_GLYPH;
							end
							`LCDCI_T_MRD: if (rlen == `LCDCI_MRD_LEN && addr_ok) begin
								rsp_type <= {`LCDCI_ACK_HI, rtype[5:0]};
								rsp_len <= `LCDCI_MRD_RLEN;
								maddr <= pay[0];
								obuf[0] <= pay[0]; // [R22]
								state <= S_MEMRD;
							end
							default: begin
							end
						endcase
					end
				end
				S_UWR: begin
					cnt <= cnt + 9'h001;
					if (cnt[3:0] == `LCDCI_USER_LAST) begin
						state <= S_SEND;
					end
				end
				S_URD: begin
					if (!cnt[4]) begin
						cnt <= cnt + 9'h001;
						dv <= 1'b1;
					end
					if (dv) begin
						obuf[cnt_d[3:0]] <= b_rd; // [R07]
					end
					if (dv && cnt_d[3:0] == `LCDCI_USER_LAST) begin
						rsp_len <= `LCDCI_USER_LEN;
						state <= S_SEND;
					end
				end
				S_SAVE, S_VERIFY: begin
					if (!cnt[8]) begin
						cnt <= cnt + 9'h001;
						dv <= 1'b1;
					end
					if (state == S_VERIFY && mis_now) begin
						mis <= 1'b1;
					end
					if (dv && cnt_d == `LCDCI_LAST_ADDR) begin
						cnt <= `LCDCI_SWEEP_FIRST;
						state <= (state == S_SAVE) ? S_VERIFY : S_SEND;
						if (state == S_VERIFY && !(mis || mis_now)) begin
							rsp_type <= {`LCDCI_ACK_HI, rtype[5:0]}; // [R11]
						end
					end
				end
				S_CLEAR: begin
					cnt <= cnt + 9'h001;
					if (cnt[7:0] == `LCDCI_LAST_ADDR) begin
						cursor_col <= `LCDCI_RST_BYTE; // [R19]
						cursor_row <= `LCDCI_RST_BYTE;
						state <= S_SEND;
					end
				end
				S_GLYPH: begin
					cnt <= cnt + 9'h001;
					if (cnt[2:0] == `LCDCI_ROW_LAST) begin
						state <= S_SEND;
					end
				end
				S_MEMRD: begin
					if (!cnt[3]) begin
						cnt <= cnt + 9'h001;
						dv <= 1'b1;
					end
					if (dv) begin
						obuf[4'({1'b0, cnt_d[2:0]} + 4'h1)] <= l_rd; // [R22]
					end
					if (dv && cnt_d[2:0] == `LCDCI_ROW_LAST) begin
						state <= S_SEND;
					end
				end
				S_SEND: begin
					if (!tx_valid) begin
						tx_valid <= 1'b1; // [R01]
						tx_byte <= sel_byte;
						tx_last <= (sidx == rsp_len + 5'h01); // [R24]
					end else if (tx_ready) begin
						tx_valid <= 1'b0;
						tx_last <= 1'b0;
						sidx <= sidx + 5'h01;
						if (tx_last) begin
							cnt <= `LCDCI_SWEEP_FIRST;
							unique case (act)
								ACT_NONE: begin
									rx_ready <= 1'b1;
									state <= S_IDLE;
								end
								ACT_REBOOT: begin
									state <= S_BOOT; // [R12]
								end
								ACT_HRST: begin
									host_reset_drive <= 1'b1; // [R13]
									tmr <= `LCDCI_HRST_MS; // [R14]
									state <= S_HOLD;
								end
								ACT_POFF: begin
									host_power_drive <= 1'b1; // [R15]
									tmr <= pulse_ms; // [R15]
									state <= S_HOLD;
								end
							endcase
						end
					end
				end
				S_HOLD: begin
					if (tmr == 12'h000) begin
						host_reset_drive <= 1'b0;
						host_power_drive <= 1'b0;
						quiet <= 1'b1; // [R14]
						state <= S_BOOT;
					end else if (ms_tick) begin
						tmr <= tmr - 12'h001;
					end
				end
				S_QUIET: begin
					if (tmr == 12'h000) begin
						rx_ready <= 1'b1;
						state <= S_IDLE;
					end else if (ms_tick) begin
						tmr <= tmr - 12'h001; // [R14]
					end
				end
			endcase
		end
	end
endmodule : lcdci_core

// ===== test/lcdci_host_sink.sv
// Host side answer sink with optional stalling
`timescale 1ns/100ps
module lcdci_host_sink (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Stall mode
	input wire logic slow,
	// Answer stream
	input wire logic tx_valid,
	input wire logic [7:0] tx_byte,
	input wire logic tx_last,
	output logic tx_ready
);
	logic [7:0] mem [0:31];
	int pos = 0;
	int cnt = 0;
	int pkts = 0;
	// ==========================================================
	// Byte capture, one answer at a time
	always @(posedge clk) begin
		if (!rst_n) begin
			tx_ready <= 1'b0;
		end else begin
			tx_ready <= slow ? ~tx_ready : 1'b1;
		end
		if (rst_n && tx_valid && tx_ready) begin
			mem[pos[4:0]] <= tx_byte;
			pos <= tx_last ? 0 : pos + 1;
			if (tx_last) begin
				cnt <= pos + 1;
				pkts <= pkts + 1;
			end
		end
	end
endmodule : lcdci_host_sink

// ===== test/lcdci_core_properties.sv
// Port checker of the display command interpreter
`timescale 1ns/100ps
module lcdci_core_check (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Streams
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_end,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_byte,
	input wire logic tx_last,
	input wire logic tx_ready,
	// Host control and fans
	input wire logic host_reset_drive,
	input wire logic host_power_drive,
	input wire logic [7:0] fan_power
);
	logic in_pkt;
	logic [7:0] cmd;
	logic [7:0] tidx;
	logic [7:0] tlen;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Command type and answer position tracking
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			in_pkt <= 1'b0;
			cmd <= 8'h00;
		end else if (rx_valid && rx_ready && !in_pkt) begin
			in_pkt <= 1'b1;
			cmd <= rx_byte;
		end else if (rx_end && rx_ready) begin
			in_pkt <= 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tidx <= 8'h00;
			tlen <= 8'h00;
		end else if (tx_valid && tx_ready) begin
			tidx <= tx_last ? 8'h00 : tidx + 8'h01;
			if (tidx == 8'h01) begin
				tlen <= tx_byte;
			end
		end
	end
	// ==========================================================
	// Assertions
	hold_busy_a: assert property (tx_valid && !tx_ready |=> tx_valid &&
		$stable(tx_byte) && $stable(tx_last)) else $error("answer byte moved");
	byte_gap_a: assert property (tx_valid && tx_ready && !tx_last |=>
		!tx_valid ##1 tx_valid) else $error("answer byte spacing wrong");
	one_way_a: assert property (!(rx_ready && tx_valid))
		else $error("receive open while answering");
	busy_end_a: assert property (rx_end && rx_ready |=> !rx_ready)
		else $error("receive still open after packet end");
	type_echo_a: assert property (tx_valid && tidx == 8'h00 |->
		tx_byte[5:0] == cmd[5:0] && tx_byte[6]) else $error("answer type wrong");
	len_last_a: assert property (tx_valid && tidx == 8'h01 |->
		tx_last == (tx_byte == 8'h00)) else $error("empty answer end wrong");
	count_last_a: assert property (tx_valid && tidx > 8'h01 |->
		tx_last == (tidx == tlen + 8'h01)) else $error("answer length wrong");
	drive_quiet_a: assert property (host_reset_drive || host_power_drive |->
		!rx_ready && !(host_reset_drive && host_power_drive))
		else $error("host pin drive overlaps");
	fan_level_a: assert property (fan_power == 8'h00 || fan_power == 8'h64)
		else $error("fan power level wrong");
	last_valid_a: assert property (tx_last |-> tx_valid)
		else $error("end mark without byte");
endmodule : lcdci_core_check
bind lcdci_core lcdci_core_check chk (.clk(clk), .rst_n(rst_n),
	.rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end),
	.rx_ready(rx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
	.tx_last(tx_last), .tx_ready(tx_ready), .host_reset_drive(host_reset_drive),
	.host_power_drive(host_power_drive), .fan_power(fan_power));

// ===== test/test_lcdci_core.sv
// Self-checking bench of the display command interpreter
`timescale 1ns/100ps
`define CHK(got, want) begin total_checks++; if ((got) !== (want)) begin \
	fail_count++; $display("CHECK FAILED %0t: got %0h want %0h", \
	$time, got, want); end end
module test_lcdci_core;
	localparam int CPM = 4;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rx_valid = 1'b0;
	logic rx_end = 1'b0;
	logic slow = 1'b0;
	logic [7:0] rx_byte = 8'h00;
	logic [11:0] pulse_ms = 12'h005;
	logic rx_ready, tx_valid, tx_last, tx_ready;
	logic host_reset_drive, host_power_drive;
	logic [7:0] tx_byte, fan_power, cursor_col, cursor_row;
	int fail_count = 0;
	int total_checks = 0;
	int cyc = 0;
	logic [7:0] txq[$];
	logic [7:0] expq[$];
	always #20 clk = ~clk;
	lcdci_core #(.CYC_PER_MS(CPM), .VERSION({16{8'h56}})) uut (.clk(clk),
		.rst_n(rst_n), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end),
		.rx_ready(rx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
		.tx_last(tx_last), .tx_ready(tx_ready), .pulse_ms(pulse_ms),
		.host_reset_drive(host_reset_drive), .host_power_drive(host_power_drive),
		.fan_power(fan_power), .cursor_col(cursor_col), .cursor_row(cursor_row));
	lcdci_host_sink sink (.clk(clk), .rst_n(rst_n), .slow(slow),
		.tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
		.tx_ready(tx_ready));
	// ==========================================================
	// Shared tasks
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	task automatic run();
		int base;
		int k;
		k = 0;
		while (rx_ready !== 1'b1 && k < 20000) begin
			@(negedge clk);
			k++;
		end
		base = sink.pkts;
		foreach (txq[i]) begin
			@(posedge clk);
			rx_valid <= 1'b1;
			rx_byte <= txq[i];
		end
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_end <= 1'b1;
		@(posedge clk);
		rx_end <= 1'b0;
		k = 0;
		while (sink.pkts == base && k < 1000) begin
			@(negedge clk);
			k++;
		end
		`CHK(sink.pkts, base + 1)
		`CHK(sink.cnt, expq.size())
		foreach (expq[i]) `CHK(sink.mem[i], expq[i])
		txq.delete();
		expq.delete();
	endtask : run
	task automatic pulse_len(input logic pwr, input int ms);
		int c;
		c = 0;
		while ((pwr ? host_power_drive : host_reset_drive) !== 1'b1 && c < 300)
			@(negedge clk) c++;
		c = 0;
		while ((pwr ? host_power_drive : host_reset_drive) === 1'b1 && c < 9000)
			@(negedge clk) c++;
		`CHK(c >= (ms - 1) * CPM && c <= (ms + 1) * CPM, 1'b1)
		c = 0;
		while (rx_ready !== 1'b1 && c < 20000) @(negedge clk) c++;
		`CHK(c <= 3001 * CPM + 300, 1'b1)
	endtask : pulse_len
	// ==========================================================
	// Scenarios
	task automatic t_fan();
		repeat (10) @(negedge clk);
		`CHK(fan_power, 8'h00)
		while (rx_ready !== 1'b1) @(negedge clk);
		repeat (500 * CPM + 2 * CPM) @(negedge clk);
		`CHK(fan_power, 8'h64)
	endtask : t_fan
	task automatic t_echo();
		txq = '{8'h00, 8'h00};
		expq = '{8'h40, 8'h00};
		run();
		txq = '{8'h00, 8'h10};
		expq = '{8'h40, 8'h10};
		for (int i = 0; i < 16; i++) txq.push_back(8'hF0 - i);
		for (int i = 0; i < 16; i++) expq.push_back(8'hF0 - i);
		run();
		txq = '{8'h00, 8'h11};
		for (int i = 0; i < 17; i++) txq.push_back(8'h01);
		expq = '{8'hC0, 8'h00};
		run();
		txq = '{8'h07, 8'h00};
		expq = '{8'hC7, 8'h00};
		run();
		txq = '{8'h81, 8'h00};
		expq = '{8'hC1, 8'h00};
		run();
	endtask : t_echo
	task automatic t_version();
		slow <= 1'b1;
		txq = '{8'h01, 8'h00};
		expq = '{8'h41, 8'h10};
		for (int i = 0; i < 16; i++) expq.push_back(8'h56);
		run();
		slow <= 1'b0;
	endtask : t_version
	task automatic t_user();
		txq = '{8'h02, 8'h10};
		for (int i = 0; i < 16; i++) txq.push_back(8'hA0 + i);
		expq = '{8'h42, 8'h00};
		run();
		txq = '{8'h02, 8'h0F};
		for (int i = 0; i < 15; i++) txq.push_back(8'h55);
		expq = '{8'hC2, 8'h00};
		run();
		txq = '{8'h03, 8'h00};
		expq = '{8'h43, 8'h10};
		for (int i = 0; i < 16; i++) expq.push_back(8'hA0 + i);
		run();
	endtask : t_user
	task automatic t_screen();
		txq = '{8'h06, 8'h00};
		expq = '{8'h46, 8'h00};
		run();
		`CHK(cursor_col, 8'h00)
		`CHK(cursor_row, 8'h00)
		txq = '{8'h0A, 8'h01, 8'h93};
		expq = '{8'h4A, 8'h09, 8'h93};
		for (int i = 0; i < 8; i++) expq.push_back(8'h20);
		run();
		foreach (txq[i]) txq[i] = 8'h00;
		for (int a = 0; a < 3; a++) begin
			txq = '{8'h0A, 8'h01, (a == 0) ? 8'h94 : (a == 1) ? 8'h3F : 8'hF4};
			expq = '{8'hCA, 8'h00};
			run();
		end
		txq = '{8'h09, 8'h09, 8'h02};
		for (int i = 0; i < 8; i++) txq.push_back(8'h07 * i);
		expq = '{8'h49, 8'h00};
		run();
		txq = '{8'h09, 8'h09, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00};
		expq = '{8'hC9, 8'h00};
		run();
		txq = '{8'h09, 8'h09, 8'h02, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00};
		expq = '{8'hC9, 8'h00};
		run();
	endtask : t_screen
	task automatic t_boot();
		txq = '{8'h04, 8'h00};
		expq = '{8'h44, 8'h00};
		run();
		txq = '{8'h09, 8'h09, 8'h02};
		for (int i = 0; i < 8; i++) txq.push_back(8'h3F);
		expq = '{8'h49, 8'h00};
		run();
		txq = '{8'h05, 8'h03, 8'h08, 8'h12, 8'h62};
		expq = '{8'hC5, 8'h00};
		run();
		txq = '{8'h05, 8'h03, 8'h08, 8'h12, 8'h63};
		expq = '{8'h45, 8'h00};
		run();
		txq = '{8'h0A, 8'h01, 8'h50};
		expq = '{8'h4A, 8'h09, 8'h50};
		for (int i = 0; i < 8; i++) expq.push_back(8'h07 * i);
		run();
	endtask : t_boot
	task automatic t_host();
		txq = '{8'h05, 8'h03, 8'h0C, 8'h1C, 8'h61};
		expq = '{8'h45, 8'h00};
		run();
		pulse_len(1'b0, 1500);
		txq = '{8'h05, 8'h03, 8'h03, 8'h0B, 8'h5F};
		expq = '{8'h45, 8'h00};
		run();
		pulse_len(1'b1, 5);
	endtask : t_host
	// ==========================================================
	// Main sequence and time limit
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_fan();
		t_echo();
		t_version();
		t_user();
		t_screen();
		t_boot();
		t_host();
		end_sim();
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			fail_count++;
			end_sim();
		end
	end
endmodule : test_lcdci_core
